// [logic/reset_ctrl_cfg.svh]
// Purpose: Constants for the system reset controller
// Assumes: 20 MHz system clock
// Notes: Timing counts derived from times in ns
`ifndef RESET_CTRL_CFG_SVH
`define RESET_CTRL_CFG_SVH

`define RC_NUM_SRC 9
`define RC_SRC_POR 0
`define RC_SRC_PIN 1
`define RC_SRC_CMP 2
`define RC_SRC_SW 3
`define RC_SRC_VMON 4
`define RC_SRC_WDT 5
`define RC_SRC_MCD 6
`define RC_SRC_FLASH 7
`define RC_SRC_USB 8
`define RC_NUM_PORTS 40
`define RC_PC_W 16
`define RC_PC_RESET 16'h0000
`define RC_CLKSEL_W 2
`define RC_CLKSEL_INTERNAL 2'h0
`define RC_CLK_PERIOD_NS 50
`define RC_HOLD_NS 200
`define RC_HOLD_CYCLES ((`RC_HOLD_NS + `RC_CLK_PERIOD_NS - 1) / `RC_CLK_PERIOD_NS)
`define RC_CNT_W 4
`define RC_MEM_DEPTH 16
`define RC_MEM_AW 4
`define RC_MEM_DW 8

`endif

// [logic/reset_ctrl_pkg.sv]
// Purpose: Types for the system reset controller
// Assumes: reset_ctrl_cfg.svh included first
// Notes: Types only
`include "reset_ctrl_cfg.svh"
package reset_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_RESET,
        ST_HOLD,
        ST_RUN
    } rst_state_e;

    typedef struct packed {
        logic [`RC_NUM_PORTS-1:0] latch;
        logic [`RC_NUM_PORTS-1:0] open_drain;
        logic [`RC_NUM_PORTS-1:0] pullup_en;
    } port_ctrl_s;

    typedef struct packed {
        logic [`RC_PC_W-1:0] pc;
        logic [`RC_CLKSEL_W-1:0] clk_sel;
        logic wdt_en;
        logic irq_en;
        logic tmr_en;
    } core_ctrl_s;
endpackage

// [logic/cause_mem.sv]
// Purpose: Small retained memory, untouched by reset
// Assumes: Single clock, registered read
// Notes: No reset on the array so contents survive
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_cfg.svh"
module cause_mem (
    // Clock
    input wire logic ref_clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [`RC_MEM_AW-1:0] wr_addr_i,
    input wire logic [`RC_MEM_DW-1:0] wr_data_i,
    // Read port
    input wire logic [`RC_MEM_AW-1:0] rd_addr_i,
    output logic [`RC_MEM_DW-1:0] rd_data_o
);
    logic [`RC_MEM_DW-1:0] mem [`RC_MEM_DEPTH];

    // Array carries no reset term at all
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule
`default_nettype wire

// [logic/system_reset_controller.sv]
// Purpose: Combine reset sources into one chip reset and sequence exit
// Assumes: Sources active high, external pin active low, 20 MHz clock
// Notes: rst_n_i is the power-on reset itself
// Functional notes
// - Any active reset source puts the chip in reset and halts the core; the code ignores any source but power-on or supply whose src_en_i bit is clear.
// - Entering reset loads defaults except power-on-only bits.
// - Port pins are forced to a fixed state during reset.
// - Entering reset disables interrupts and timers.
// - RAM contents are not touched by any reset except power-on, which clears the power-on-only word at address 0.
// - Reset sets every port latch to one in open-drain mode.
// - Weak pull-ups are on during reset and follow pullup_func_i after release.
// - For power-on or supply-monitor reset the reset pin is driven low until exit.
// - On exit the program counter clears and the clock selects the internal oscillator.
// - On exit the watchdog is enabled and running.
// - Fetch starts at code address 0x0000 after release.
// - Nine sources: power-on, pin, comparator, software, supply, watchdog, clock, flash, USB.
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_cfg.svh"
module system_reset_controller (
    // Clock and power-on reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Internal reset sources
    input wire logic cmp_rst_i,
    input wire logic sw_rst_i,
    input wire logic vmon_rst_i,
    input wire logic wdt_rst_i,
    input wire logic mcd_rst_i,
    input wire logic flash_rst_i,
    input wire logic usb_rst_i,
    // Source enables
    input wire logic [`RC_NUM_SRC-1:0] src_en_i,
    // External reset pin, open drain
    input wire logic external_reset_pin_n_i,
    output logic external_reset_pin_n_o,
    output logic external_reset_pin_n_oe_o,
    // Functional port values and power-on-only bits from the core
    input wire logic [`RC_NUM_PORTS-1:0] port_func_i,
    input wire logic [`RC_NUM_PORTS-1:0] port_od_func_i,
    input wire logic [`RC_NUM_PORTS-1:0] pullup_func_i,
    input wire logic por_only_wr_i,
    input wire logic [`RC_MEM_DW-1:0] por_only_data_i,
    // Chip reset and core control
    output logic chip_rst_o,
    output logic core_halt_o,
    output logic regs_init_o,
    output reset_ctrl_pkg::core_ctrl_s core_ctrl_o,
    output reset_ctrl_pkg::port_ctrl_s port_ctrl_o,
    // Reset cause and retained bits
    output logic [`RC_NUM_SRC-1:0] reset_cause_o,
    output logic [`RC_MEM_DW-1:0] por_only_bits_o
);
    // ------------------------------------------------------------
    // Source synchronisation
    // ------------------------------------------------------------
    // Pin and some sources come from other domains; two flops each
    logic [`RC_NUM_SRC-1:1] src_meta;
    logic [`RC_NUM_SRC-1:1] src_sync;
    // Our own pull on the pin must not read back as an external request
    logic pin_self_d1;
    logic pin_self_d2;
    wire [`RC_NUM_SRC-1:1] src_raw = {usb_rst_i, flash_rst_i, mcd_rst_i, wdt_rst_i,
                                      vmon_rst_i, sw_rst_i, cmp_rst_i,
                                      ~external_reset_pin_n_i};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_meta <= '0;
            src_sync <= '0;
            pin_self_d1 <= 1'b1;
            pin_self_d2 <= 1'b1;
        end else begin
            src_meta <= src_raw;
            src_sync <= src_meta;
            // Delayed to line up with the two synchroniser stages
            pin_self_d1 <= external_reset_pin_n_oe_o;
            pin_self_d2 <= pin_self_d1;
        end
    end

    // ------------------------------------------------------------
    // Source combination
    // ------------------------------------------------------------
    logic por_pending;
    logic [`RC_NUM_SRC-1:0] src_vec;
    logic [`RC_NUM_SRC-1:0] src_active;
    logic any_src;
    logic pin_driven_cause;

    // Power-on and supply monitor can never be masked off
    assign src_vec = {src_sync[`RC_NUM_SRC-1:2], src_sync[`RC_SRC_PIN] & ~pin_self_d2,
                      por_pending};
    genvar g;
    generate
        for (g = 0; g < `RC_NUM_SRC; g++) begin : g_src
            if (g == `RC_SRC_POR || g == `RC_SRC_VMON) begin : g_fixed
                assign src_active[g] = src_vec[g];
            end else begin : g_mask
                assign src_active[g] = src_vec[g] & src_en_i[g];
            end
        end
    endgenerate
    assign any_src = |src_active;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    reset_ctrl_pkg::rst_state_e state;
    reset_ctrl_pkg::rst_state_e next_state;
    logic [`RC_CNT_W-1:0] hold_cnt;
    logic [`RC_NUM_SRC-1:0] cause;
    logic [`RC_NUM_SRC-1:0] next_cause;
    logic in_reset;
    logic hold_done;

    assign hold_done = (hold_cnt == `RC_CNT_W'(`RC_HOLD_CYCLES - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            reset_ctrl_pkg::ST_RESET: begin
                if (!any_src) begin
                    next_state = reset_ctrl_pkg::ST_HOLD;
                end
            end
            reset_ctrl_pkg::ST_HOLD: begin
                if (any_src) begin
                    next_state = reset_ctrl_pkg::ST_RESET;
                end else if (hold_done) begin
                    next_state = reset_ctrl_pkg::ST_RUN;
                end
            end
            reset_ctrl_pkg::ST_RUN: begin
                if (any_src) begin
                    next_state = reset_ctrl_pkg::ST_RESET;
                end
            end
        endcase
    end

    assign in_reset = (next_state != reset_ctrl_pkg::ST_RUN);
    // Entry from run restarts the record; inside reset it gathers
    assign next_cause = (state != reset_ctrl_pkg::ST_RUN) ? (cause | src_active)
                      : (any_src ? src_active : cause);
    // Next cause, so a stale record never pulls the pin at entry
    assign pin_driven_cause = next_cause[`RC_SRC_POR] | next_cause[`RC_SRC_VMON];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= reset_ctrl_pkg::ST_RESET;
            hold_cnt <= '0;
            por_pending <= 1'b1;
        end else begin
            state <= next_state;
            por_pending <= 1'b0;
            if (next_state == reset_ctrl_pkg::ST_HOLD) begin
                hold_cnt <= hold_cnt + `RC_CNT_W'(1);
            end else begin
                hold_cnt <= '0;
            end
        end
    end

    // Cause latches on each new reset entry, gathers further sources while in reset and holds in run
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cause <= `RC_NUM_SRC'(1);
        end else begin
            cause <= next_cause;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    reset_ctrl_pkg::port_ctrl_s next_port;
    reset_ctrl_pkg::core_ctrl_s reset_core;

    assign reset_core.pc = `RC_PC_RESET;
    assign reset_core.clk_sel = `RC_CLKSEL_INTERNAL;
    assign reset_core.wdt_en = 1'b1;
    assign reset_core.irq_en = 1'b0;
    assign reset_core.tmr_en = 1'b0;

    // Pull-ups forced on in reset; core clears them only later
    assign next_port.latch = in_reset ? '1 : port_func_i;
    assign next_port.open_drain = in_reset ? '1 : port_od_func_i;
    assign next_port.pullup_en = in_reset ? '1 : pullup_func_i;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_rst_o <= 1'b1;
            core_halt_o <= 1'b1;
            regs_init_o <= 1'b1;
            core_ctrl_o <= '{pc: `RC_PC_RESET, clk_sel: `RC_CLKSEL_INTERNAL,
                             wdt_en: 1'b1, irq_en: 1'b0, tmr_en: 1'b0};
            port_ctrl_o <= '{latch: '1, open_drain: '1, pullup_en: '1};
            external_reset_pin_n_o <= 1'b0;
            external_reset_pin_n_oe_o <= 1'b1;
            reset_cause_o <= '0;
        end else begin
            chip_rst_o <= in_reset;
            core_halt_o <= in_reset;
            regs_init_o <= in_reset;
            // Defaults are driven at all times; nothing changes them after exit
            core_ctrl_o <= reset_core;
            port_ctrl_o <= next_port;
            external_reset_pin_n_o <= 1'b0;
            external_reset_pin_n_oe_o <= in_reset & pin_driven_cause;
            reset_cause_o <= cause;
        end
    end

    // ------------------------------------------------------------
    // Power-on-only bits, kept across non power-on resets
    // ------------------------------------------------------------
    logic por_only_clear;
    logic mem_wr;
    logic [`RC_MEM_DW-1:0] mem_wdata;

    assign por_only_clear = por_pending;
    assign mem_wr = por_only_clear | (por_only_wr_i & ~in_reset);
    assign mem_wdata = por_only_clear ? '0 : por_only_data_i;

    cause_mem u_cause_mem (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(mem_wr),
        .wr_addr_i(`RC_MEM_AW'(0)),
        .wr_data_i(mem_wdata),
        .rd_addr_i(`RC_MEM_AW'(0)),
        .rd_data_o(por_only_bits_o)
    );
endmodule
`default_nettype wire

// [verification/reset_ctrl_checker.sv]
// Purpose: Port assertions for the reset controller
// Assumes: Bound to system_reset_controller
// Notes: Release bound allows sync, hold and output stages
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_cfg.svh"
module reset_ctrl_checker (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Sources
    input wire logic cmp_rst_i,
    input wire logic sw_rst_i,
    input wire logic vmon_rst_i,
    input wire logic wdt_rst_i,
    input wire logic mcd_rst_i,
    input wire logic flash_rst_i,
    input wire logic usb_rst_i,
    input wire logic [`RC_NUM_SRC-1:0] src_en_i,
    input wire logic external_reset_pin_n_i,
    // Outputs
    input wire logic external_reset_pin_n_o,
    input wire logic external_reset_pin_n_oe_o,
    input wire logic chip_rst_o,
    input wire logic core_halt_o,
    input wire reset_ctrl_pkg::core_ctrl_s core_ctrl_o,
    input wire reset_ctrl_pkg::port_ctrl_s port_ctrl_o
);
    logic act;
    logic [3:0] idle;
    assign act = vmon_rst_i | (!external_reset_pin_n_i & src_en_i[1])
        | (cmp_rst_i & src_en_i[2]) | (sw_rst_i & src_en_i[3]) | (wdt_rst_i & src_en_i[5])
        | (mcd_rst_i & src_en_i[6]) | (flash_rst_i & src_en_i[7]) | (usb_rst_i & src_en_i[8]);
    // Quiet cycles since the last active source
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) idle <= 4'h0;
        else if (act) idle <= 4'h0;
        else if (idle != 4'hf) idle <= idle + 4'h1;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    halt_tracks_a: assert property (core_halt_o == chip_rst_o)
        else $error("halt differs from chip reset");
    source_entry_a: assert property (act [*5] |-> chip_rst_o)
        else $error("active source without reset");
    sync_release_a: assert property (idle == 4'hc |-> !chip_rst_o)
        else $error("reset not released");
    ports_known_a: assert property (chip_rst_o |-> &port_ctrl_o.latch && &port_ctrl_o.open_drain)
        else $error("ports not forced");
    pullup_on_a: assert property (chip_rst_o |-> &port_ctrl_o.pullup_en)
        else $error("pullups off in reset");
    irq_tmr_off_a: assert property (chip_rst_o |-> !core_ctrl_o.irq_en && !core_ctrl_o.tmr_en)
        else $error("irq or timer on in reset");
    exit_state_a: assert property ($fell(chip_rst_o) |-> core_ctrl_o.pc == `RC_PC_RESET
        && core_ctrl_o.clk_sel == `RC_CLKSEL_INTERNAL && core_ctrl_o.wdt_en) else $error("bad exit state");
    pin_pull_a: assert property ($rose(vmon_rst_i) |-> ##[1:6] (external_reset_pin_n_oe_o
        && !external_reset_pin_n_o)) else $error("pin not driven low");
    pin_free_a: assert property (external_reset_pin_n_oe_o |-> chip_rst_o)
        else $error("pin driven outside reset");
    cover property ($fell(chip_rst_o));
    cover property ($rose(external_reset_pin_n_oe_o));
    cover property (sw_rst_i && !src_en_i[3]);
endmodule
`default_nettype wire

// [verification/reset_source_model.sv]
// Purpose: Reset sources and the pulled-up reset pin
// Assumes: Bench raises requests by bit index
// Notes: Sources lag a cycle, like slow detectors
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_cfg.svh"
module reset_source_model (
    // Clock and requests
    input wire logic ref_clk_i,
    input wire logic [`RC_NUM_SRC-1:0] req_i,
    // Device pin drive
    input wire logic pin_oe_i,
    input wire logic pin_val_i,
    // Source lines
    output logic [`RC_NUM_SRC-1:0] src_o,
    output logic pin_level_o
);
    always_ff @(posedge ref_clk_i) src_o <= req_i;
    // Released pin floats up to the pull-up level
    assign pin_level_o = !((pin_oe_i && !pin_val_i) || src_o[`RC_SRC_PIN]);
endmodule
`default_nettype wire

// [verification/system_reset_controller_tb_top.sv]
// Purpose: Scenario bench for the reset controller
// Assumes: 20 MHz clock, sources via the model
// Notes: Outputs sampled on the falling edge
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_cfg.svh"
module system_reset_controller_tb_top;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, pin_lvl, pin_o, pin_oe, chip, halt, init, wr = 1'b0;
    logic [8:0] req = '0, src, en = 9'h1ff, cause;
    logic [7:0] wdat = 8'h00, keep;
    logic [39:0] pf = 40'h12_3456_789a, pod = 40'h00_ff00_ff00, ppu = 40'h0f_0f0f_0f0f;
    reset_ctrl_pkg::core_ctrl_s core;
    reset_ctrl_pkg::port_ctrl_s port;
    int bad_count = 0, num_checks = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    reset_source_model reset_source_model_inst (.ref_clk_i(ref_clk_i), .req_i(req),
        .pin_oe_i(pin_oe), .pin_val_i(pin_o), .src_o(src), .pin_level_o(pin_lvl));
    system_reset_controller system_reset_controller_inst (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .cmp_rst_i(src[2]), .sw_rst_i(src[3]), .vmon_rst_i(src[4]),
        .wdt_rst_i(src[5]), .mcd_rst_i(src[6]), .flash_rst_i(src[7]), .usb_rst_i(src[8]),
        .src_en_i(en), .external_reset_pin_n_i(pin_lvl), .external_reset_pin_n_o(pin_o),
        .external_reset_pin_n_oe_o(pin_oe), .port_func_i(pf), .port_od_func_i(pod),
        .pullup_func_i(ppu), .por_only_wr_i(wr), .por_only_data_i(wdat), .chip_rst_o(chip),
        .core_halt_o(halt), .regs_init_o(init), .core_ctrl_o(core), .port_ctrl_o(port),
        .reset_cause_o(cause), .por_only_bits_o(keep));
    task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_rst(input logic v);
        for (int i = 0; i < 60 && chip !== v; i++) @(negedge ref_clk_i);
        chk("chip_rst", v, chip);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_por();
        @(negedge ref_clk_i);
        chk("por_pin", 2'b10, {pin_oe, pin_lvl});
        chk("por_ports", {120{1'b1}}, port);
        @(posedge ref_clk_i) rst_n_i <= 1'b1;
        wait_rst(1'b0);
        chk("core", {`RC_PC_RESET, `RC_CLKSEL_INTERNAL, 3'b100}, core);
        chk("run_ports", {pf, pod, ppu}, port);
        chk("pin_free", 2'b01, {pin_oe, pin_lvl});
        chk("run_flags", 2'b00, {halt, init});
    endtask
    task automatic t_sources();
        for (int s = 1; s < 9; s++) begin
            @(posedge ref_clk_i) req <= 9'h1 << s;
            wait_rst(1'b1);
            chk("pin_entry", s == 4, pin_oe);
            @(negedge ref_clk_i);
            chk("halt_ports", {1'b1, {80{1'b1}}}, {halt, port.latch, port.open_drain});
            chk("init_rst", 1'b1, init);
            chk("pin_drive", s == 4, pin_oe);
            @(posedge ref_clk_i) req <= '0;
            wait_rst(1'b0);
            chk("cause", 9'h1 << s, cause);
        end
    endtask
    task automatic t_masked();
        @(posedge ref_clk_i) en <= 9'h000;
        req <= 9'h008;
        repeat (12) @(negedge ref_clk_i);
        chk("masked", 1'b0, chip);
        @(posedge ref_clk_i) req <= 9'h010;
        wait_rst(1'b1);
        @(posedge ref_clk_i) req <= '0;
        en <= 9'h1ff;
        wait_rst(1'b0);
    endtask
    task automatic t_retain();
        @(posedge ref_clk_i) wr <= 1'b1;
        wdat <= 8'ha5;
        @(posedge ref_clk_i) wr <= 1'b0;
        req <= 9'h008;
        wait_rst(1'b1);
        @(posedge ref_clk_i) wr <= 1'b1;
        wdat <= 8'h3c;
        @(posedge ref_clk_i) wr <= 1'b0;
        req <= '0;
        wait_rst(1'b0);
        repeat (2) @(negedge ref_clk_i);
        chk("retained", 8'ha5, keep);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        t_por();
        t_sources();
        t_masked();
        t_retain();
        summarize();
    end
    initial begin
        #(4000 * 50);
        bad_count++;
        summarize();
    end
endmodule
bind system_reset_controller reset_ctrl_checker reset_ctrl_checker_inst (.ref_clk_i, .rst_n_i,
    .cmp_rst_i, .sw_rst_i, .vmon_rst_i, .wdt_rst_i, .mcd_rst_i, .flash_rst_i, .usb_rst_i,
    .src_en_i, .external_reset_pin_n_i, .external_reset_pin_n_o, .external_reset_pin_n_oe_o,
    .chip_rst_o, .core_halt_o, .core_ctrl_o, .port_ctrl_o);
`default_nettype wire
